/* core/irc_pkg.sv */
package irc_pkg;

  // byte addresses of the register words
  localparam logic [7:0] ADDR_EDGE_SEL   = 8'h00;
  localparam logic [7:0] ADDR_PRIM_CTL0  = 8'h04;
  localparam logic [7:0] ADDR_PRIM_CTL1  = 8'h08;
  localparam logic [7:0] ADDR_PRIM_CTL2  = 8'h0c;
  localparam logic [7:0] ADDR_GROUP0     = 8'h10;
  localparam logic [7:0] ADDR_GROUP2     = 8'h14;
  localparam logic [7:0] ADDR_GROUP3     = 8'h18;
  localparam logic [7:0] ADDR_LVD_CTL    = 8'h1c;
  localparam logic [7:0] ADDR_TOUCH_CTL  = 8'h20;
  localparam logic [7:0] ADDR_TOUCH_SLOT = 8'h24;
  localparam logic [7:0] ADDR_TOUCH_CF   = 8'h28;
  localparam logic [7:0] ADDR_TOUCH_GEN  = 8'h2c;

  localparam logic [7:0] RST_REG8 = 8'h00;

  // edge select fields
  localparam int EDGE_A_LSB = 0;
  localparam int EDGE_B_LSB = 2;
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // primary control 0
  localparam int C0_GIE   = 0;
  localparam int C0_PROTE = 1;
  localparam int C0_PAE   = 2;
  localparam int C0_S0E   = 3;
  localparam int C0_PROTF = 4;
  localparam int C0_PAF   = 5;
  localparam int C0_S0F   = 6;
  // primary control 1
  localparam int C1_S2E  = 1;
  localparam int C1_S3E  = 2;
  localparam int C1_TB0E = 3;
  localparam int C1_S2F  = 5;
  localparam int C1_S3F  = 6;
  localparam int C1_TB0F = 7;
  // primary control 2
  localparam int C2_TB1E = 0;
  localparam int C2_PBE  = 1;
  localparam int C2_TKE  = 2;
  localparam int C2_ADE  = 3;
  localparam int C2_TB1F = 4;
  localparam int C2_PBF  = 5;
  localparam int C2_TKF  = 6;
  localparam int C2_ADF  = 7;
  // shared groups: member 0 at enable 0 / flag 4, member 1 at enable 1 / flag 5
  localparam int G_M0E = 0;
  localparam int G_M1E = 1;
  localparam int G_M0F = 4;
  localparam int G_M1F = 5;
  // supply monitor control
  localparam int LV_SEL_LSB = 0;
  localparam int LV_EN      = 4;
  localparam int LV_OUT     = 5;
  // touch control
  localparam int TK_START   = 0;
  localparam int TK_KEY1_EN = 1;
  localparam int TK_KEY2_EN = 2;
  localparam int TK_SYSCLK  = 3;
  localparam int TK_SLOT_OV = 5;
  localparam int TK_CF_OV   = 6;
  localparam int TK_GEN_OV  = 7;

  // timing
  localparam int CLK_PERIOD_NS          = 10;
  localparam int LOW_SUPPLY_IRQ_DELAY_NS = 15000;
  localparam int LOW_SUPPLY_IRQ_CYC =
    (LOW_SUPPLY_IRQ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TK_SYS_DIV = 4;

  // vector indices in priority order, 0 highest
  localparam logic [3:0] VEC_PROT  = 4'h0;
  localparam logic [3:0] VEC_PIN_A = 4'h1;
  localparam logic [3:0] VEC_S0    = 4'h2;
  localparam logic [3:0] VEC_S2    = 4'h3;
  localparam logic [3:0] VEC_S3    = 4'h4;
  localparam logic [3:0] VEC_TB0   = 4'h5;
  localparam logic [3:0] VEC_TB1   = 4'h6;
  localparam logic [3:0] VEC_PIN_B = 4'h7;
  localparam logic [3:0] VEC_TOUCH = 4'h8;
  localparam logic [3:0] VEC_ADC   = 4'h9;
  localparam int NUM_VEC = 10;

  typedef enum logic [1:0] {
    TS_IDLE = 2'b01,
    TS_RUN  = 2'b10
  } irc_scan_e;

  // one-cycle event pulses from peripherals on the system clock
  typedef struct packed {
    logic protection;
    logic ctm_a;
    logic ctm_p;
    logic ptm_a;
    logic ptm_p;
    logic eeprom;
    logic tbase0;
    logic tbase1;
    logic adc;
  } irc_event_s;

  typedef struct packed {
    logic       req;
    logic [3:0] vec;
  } irc_irq_s;

endpackage : irc_pkg

/* core/irc_top.sv */
// Notes on behaviour
// RQ1: touch unit raises one request, on slot counter overflow; only enabled keys count.
// RQ2: slot overflow clears frequency, general, unit period and slot counters.
// RQ3: rising edge of scan start begins detection and restarts oscillators together.
// RQ4: slot overflow flag set on overflow, raises request, only software clears it.
// RQ5: frequency count overflow flag set on counter overflow, software clears it.
// RQ6: general count overflow flag set on counter overflow, software clears it.
// RQ7: three-bit supply threshold field picks one of eight levels, 000 lowest.
// RQ8: read-only bit 5 reads 1 while supply is below the selected threshold.
// RQ9: bit 4 enables the supply monitor; clearing it switches the monitor off.
// RQ10: software waits for settling and tolerates chatter on the low supply bit.
// RQ11: low supply request flag is set a fixed delay after low supply rises.
// RQ12: low supply request wakes from idle; setting the flag beforehand avoids it. Here wake is the OR of flag levels, so a flag set beforehand holds wake high.
// RQ13: two-bit edge fields per pin: off, rising, falling, both.
// RQ14: bit 0 of primary control 0 is global enable; zero blocks all interrupts.
// RQ15: each source has a read-write request flag and a separate enable bit.
// RQ16: primary control 0 holds shared0, pin a, protection flags and enables.
// RQ17: group registers hold timer, memory and low supply member flags and enables.
// RQ18: flags set on events regardless of enable; vectoring needs the enable.
// RQ19: acceptance clears global enable; requests during service are still latched.
// RQ20: any request flag being set wakes the device.
// RQ21: shared request raised when an enabled member flag becomes set.
// RQ22: pending enabled requests go out in fixed priority; accepted flag is cleared.
//
// The AHB-Lite slave port and the register offsets were decided locally.
module irc_top (
  input  wire logic              clk,
  input  wire logic              rst,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic [31:0]            hrdata,
  output logic                   hresp,
  // pins and analog, asynchronous
  input  wire logic              ext_pin_a,
  input  wire logic              ext_pin_b,
  input  wire logic              supply_below,
  input  wire logic [1:0]        touch_key_osc,
  input  wire logic              touch_ref_osc,
  output logic                   supply_monitor_enable,
  output logic [2:0]             supply_threshold_sel,
  output logic                   touch_osc_run,
  // peripheral events, same clock
  input  wire irc_pkg::irc_event_s events,
  // core side
  output irc_pkg::irc_irq_s      irq,
  input  wire logic              irq_ack,
  output logic                   wake
);
  import irc_pkg::*;

  function automatic logic edge_hit(input logic [1:0] sel, input logic rise,
                                    input logic fall);
    edge_hit = (sel[0] & rise) | (sel[1] & fall);
  endfunction : edge_hit

  // ---------------- input synchronisers ----------------
  logic [5:0] sync1_ff;
  logic [5:0] sync2_ff;
  logic [5:0] sync3_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_ff <= 6'h00;
      sync2_ff <= 6'h00;
      sync3_ff <= 6'h00;
    end else begin
      sync1_ff <= {supply_below, touch_ref_osc, touch_key_osc, ext_pin_b, ext_pin_a};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end
  logic [4:0] rise_w;
  logic [4:0] fall_w;
  assign rise_w = sync2_ff[4:0] & ~sync3_ff[4:0];
  assign fall_w = ~sync2_ff[4:0] & sync3_ff[4:0];

  // ---------------- ahb-lite slave ----------------
  logic       wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic       take_w;
  assign take_w    = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= take_w & hwrite;
      wr_addr_ff <= {haddr[7:2], 2'h0};
    end
  end
  function automatic logic wr_to(input logic [7:0] a, input logic pend,
                                 input logic [7:0] wa);
    wr_to = pend & (wa == a);
  endfunction : wr_to
  logic [7:0] wd;
  assign wd = hwdata[7:0];

  // ---------------- register state ----------------
  logic [7:0]  edge_sel_ff;
  logic [7:0]  ctl0_ff;
  logic [7:0]  ctl1_ff;
  logic [7:0]  ctl2_ff;
  logic [7:0]  grp0_ff;
  logic [7:0]  grp2_ff;
  logic [7:0]  grp3_ff;
  logic [4:0]  lvd_ctl_ff;
  logic [7:0]  tk_ctl_ff;
  logic [7:0]  tk_slot_preset_ff;
  logic [15:0] tk_cf_result_ff;
  logic [15:0] tk_gen_result_ff;
  logic        low_supply_out;

  // ---------------- supply monitor ----------------
  logic        lv_rise_ff;
  logic        lv_arm_ff;
  logic [15:0] lv_cnt_ff;
  logic        lv_set_w;
  assign supply_monitor_enable = lvd_ctl_ff[LV_EN];                         // [RQ9]
  assign supply_threshold_sel  = lvd_ctl_ff[LV_SEL_LSB +: 3];               // [RQ7]
  assign low_supply_out        = lvd_ctl_ff[LV_EN] & sync2_ff[5];           // [RQ8] [RQ9]
  assign lv_set_w = lv_arm_ff & low_supply_out &
                    (lv_cnt_ff == 16'(LOW_SUPPLY_IRQ_CYC - 1));
  always_ff @(posedge clk) begin
    if (rst) begin
      lv_arm_ff  <= 1'b0;
      lv_cnt_ff  <= 16'h0000;
      lv_rise_ff <= 1'b0;
    end else begin
      lv_rise_ff <= low_supply_out;
      if (!low_supply_out) begin
        lv_arm_ff <= 1'b0;
        lv_cnt_ff <= 16'h0000;
      end else if (!lv_rise_ff) begin
        lv_arm_ff <= 1'b1;
        lv_cnt_ff <= 16'h0000;
      end else if (lv_set_w) begin
        lv_arm_ff <= 1'b0;                                                  // [RQ11]
      end else if (lv_arm_ff) begin
        lv_cnt_ff <= lv_cnt_ff + 16'h0001;
      end
    end
  end

  // ---------------- touch scan ----------------
  irc_scan_e   scan_ff;
  logic        start_d_ff;
  logic [1:0]  div_ff;
  logic [4:0]  unit_cnt_ff;
  logic [7:0]  slot_cnt_ff;
  logic [15:0] cf_cnt_ff;
  logic [15:0] gen_cnt_ff;
  logic        sys_tick_w;
  logic        slot_tick_w;
  logic        unit_wrap_w;
  logic        slot_ovf_w;
  logic        cf_inc_w;
  logic        cf_ovf_w;
  logic        gen_ovf_w;
  logic        start_rise_w;
  logic        running_w;
  assign running_w    = (scan_ff == TS_RUN);
  assign start_rise_w = tk_ctl_ff[TK_START] & ~start_d_ff;
  assign sys_tick_w   = (div_ff == 2'(TK_SYS_DIV - 1));
  assign slot_tick_w  = running_w & (tk_ctl_ff[TK_SYSCLK] ? sys_tick_w : rise_w[4]);
  assign unit_wrap_w  = slot_tick_w & (unit_cnt_ff == 5'h1f);
  assign slot_ovf_w   = unit_wrap_w & (slot_cnt_ff == 8'hff);
  assign cf_inc_w     = running_w & ((rise_w[2] & tk_ctl_ff[TK_KEY1_EN]) |
                                     (rise_w[3] & tk_ctl_ff[TK_KEY2_EN])); // [RQ1]
  assign cf_ovf_w     = cf_inc_w & (cf_cnt_ff == 16'hffff);
  assign gen_ovf_w    = slot_tick_w & (gen_cnt_ff == 16'hffff);
  assign touch_osc_run = running_w;

  always_ff @(posedge clk) begin
    if (rst) begin
      scan_ff    <= TS_IDLE;
      start_d_ff <= 1'b0;
      div_ff     <= 2'h0;
    end else begin
      start_d_ff <= tk_ctl_ff[TK_START];
      div_ff     <= sys_tick_w ? 2'h0 : div_ff + 2'h1;
      unique case (scan_ff)
        TS_IDLE: if (start_rise_w) scan_ff <= TS_RUN;                       // [RQ3]
        TS_RUN:  if (slot_ovf_w || !tk_ctl_ff[TK_START]) scan_ff <= TS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      unit_cnt_ff <= 5'h00;
      slot_cnt_ff <= 8'h00;
      cf_cnt_ff   <= 16'h0000;
      gen_cnt_ff  <= 16'h0000;
    end else if (slot_ovf_w) begin
      unit_cnt_ff <= 5'h00;                                                 // [RQ2]
      slot_cnt_ff <= 8'h00;
      cf_cnt_ff   <= 16'h0000;
      gen_cnt_ff  <= 16'h0000;
    end else if (!tk_ctl_ff[TK_START]) begin
      unit_cnt_ff <= 5'h00;
      cf_cnt_ff   <= 16'h0000;
      gen_cnt_ff  <= 16'h0000;
    end else if (start_rise_w && !running_w) begin
      unit_cnt_ff <= 5'h00;                                                 // [RQ3]
      slot_cnt_ff <= tk_slot_preset_ff;
      cf_cnt_ff   <= 16'h0000;
      gen_cnt_ff  <= 16'h0000;
    end else begin
      if (slot_tick_w) unit_cnt_ff <= unit_cnt_ff + 5'h01;
      if (unit_wrap_w) slot_cnt_ff <= slot_cnt_ff + 8'h01;
      if (slot_tick_w) gen_cnt_ff  <= gen_cnt_ff + 16'h0001;
      if (cf_inc_w)    cf_cnt_ff   <= cf_cnt_ff + 16'h0001;
    end
  end

  // results held for software once the counters are wiped
  always_ff @(posedge clk) begin
    if (rst) begin
      tk_cf_result_ff  <= 16'h0000;
      tk_gen_result_ff <= 16'h0000;
    end else if (slot_ovf_w) begin
      tk_cf_result_ff  <= cf_cnt_ff;
      tk_gen_result_ff <= gen_cnt_ff;
    end
  end

  // ---------------- edge detect on pins ----------------
  logic pin_a_ev_w;
  logic pin_b_ev_w;
  assign pin_a_ev_w = edge_hit(edge_sel_ff[EDGE_A_LSB +: 2], rise_w[0], fall_w[0]); // [RQ13]
  assign pin_b_ev_w = edge_hit(edge_sel_ff[EDGE_B_LSB +: 2], rise_w[1], fall_w[1]); // [RQ13]

  // ---------------- shared groups ----------------
  logic [2:0] grp_hit_w;
  logic [2:0] grp_hit_d_ff;
  logic [2:0] grp_rise_w;
  assign grp_hit_w[0] = |(grp0_ff[G_M1F:G_M0F] & grp0_ff[G_M1E:G_M0E]);   // [RQ21]
  assign grp_hit_w[1] = |(grp2_ff[G_M1F:G_M0F] & grp2_ff[G_M1E:G_M0E]);
  assign grp_hit_w[2] = |(grp3_ff[G_M1F:G_M0F] & grp3_ff[G_M1E:G_M0E]);
  assign grp_rise_w   = grp_hit_w & ~grp_hit_d_ff;
  always_ff @(posedge clk) begin
    if (rst) grp_hit_d_ff <= 3'h0;
    else     grp_hit_d_ff <= grp_hit_w;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      grp0_ff <= RST_REG8;
      grp2_ff <= RST_REG8;
      grp3_ff <= RST_REG8;
    end else begin
      // member flags: event sets regardless of enable, set wins over write [RQ17] [RQ18]
      grp0_ff <= (wr_to(ADDR_GROUP0, wr_pend_ff, wr_addr_ff) ? (wd & 8'h33) : grp0_ff)
                 | {2'h0, events.ctm_a, events.ctm_p, 4'h0};
      grp2_ff <= (wr_to(ADDR_GROUP2, wr_pend_ff, wr_addr_ff) ? (wd & 8'h33) : grp2_ff)
                 | {2'h0, events.ptm_a, events.ptm_p, 4'h0};
      grp3_ff <= (wr_to(ADDR_GROUP3, wr_pend_ff, wr_addr_ff) ? (wd & 8'h33) : grp3_ff)
                 | {2'h0, events.eeprom, lv_set_w, 4'h0};                   // [RQ11] [RQ12]
    end
  end

  // ---------------- primary flags ----------------
  logic [NUM_VEC-1:0] pend_w;
  logic [NUM_VEC-1:0] ack_clr_w;
  logic               take_ack_w;
  assign take_ack_w = irq_ack & irq.req;
  always_comb begin
    ack_clr_w = '0;
    if (take_ack_w) ack_clr_w[irq.vec] = 1'b1;                              // [RQ22]
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      edge_sel_ff <= RST_REG8;
      ctl0_ff     <= RST_REG8;
      ctl1_ff     <= RST_REG8;
      ctl2_ff     <= RST_REG8;
    end else begin
      if (wr_to(ADDR_EDGE_SEL, wr_pend_ff, wr_addr_ff)) edge_sel_ff <= wd & 8'h0f;
      ctl0_ff <= ((wr_to(ADDR_PRIM_CTL0, wr_pend_ff, wr_addr_ff) ? (wd & 8'h7f) : ctl0_ff)
                  & ~{1'b0, ack_clr_w[VEC_S0], ack_clr_w[VEC_PIN_A],
                      ack_clr_w[VEC_PROT], 3'h0, take_ack_w})              // [RQ19]
                 | {1'b0, grp_rise_w[0], pin_a_ev_w, events.protection, 4'h0}; // [RQ16] [RQ18]
      ctl1_ff <= ((wr_to(ADDR_PRIM_CTL1, wr_pend_ff, wr_addr_ff) ? (wd & 8'hee) : ctl1_ff)
                  & ~{ack_clr_w[VEC_TB0], ack_clr_w[VEC_S3], ack_clr_w[VEC_S2], 5'h00})
                 | {events.tbase0, grp_rise_w[2], grp_rise_w[1], 5'h00};    // [RQ15]
      ctl2_ff <= ((wr_to(ADDR_PRIM_CTL2, wr_pend_ff, wr_addr_ff) ? wd : ctl2_ff)
                  & ~{ack_clr_w[VEC_ADC], ack_clr_w[VEC_TOUCH], ack_clr_w[VEC_PIN_B],
                      ack_clr_w[VEC_TB1], 4'h0})
                 | {events.adc, slot_ovf_w, pin_b_ev_w, events.tbase1, 4'h0}; // [RQ1] [RQ4]
    end
  end

  // ---------------- touch and monitor control registers ----------------
  always_ff @(posedge clk) begin
    if (rst) begin
      tk_ctl_ff         <= RST_REG8;
      tk_slot_preset_ff <= RST_REG8;
      lvd_ctl_ff        <= 5'h00;
    end else begin
      if (wr_to(ADDR_TOUCH_SLOT, wr_pend_ff, wr_addr_ff)) tk_slot_preset_ff <= wd;
      if (wr_to(ADDR_LVD_CTL, wr_pend_ff, wr_addr_ff)) lvd_ctl_ff <= wd[4:0] & 5'h17;
      // flags only cleared by software, hardware set wins [RQ4] [RQ5] [RQ6]
      tk_ctl_ff <= (wr_to(ADDR_TOUCH_CTL, wr_pend_ff, wr_addr_ff) ? (wd & 8'hef) : tk_ctl_ff)
                   | {gen_ovf_w, cf_ovf_w, slot_ovf_w, 5'h00};
    end
  end

  // ---------------- priority and core request ----------------
  assign pend_w = {ctl2_ff[C2_ADF] & ctl2_ff[C2_ADE],
                   ctl2_ff[C2_TKF] & ctl2_ff[C2_TKE],
                   ctl2_ff[C2_PBF] & ctl2_ff[C2_PBE],
                   ctl2_ff[C2_TB1F] & ctl2_ff[C2_TB1E],
                   ctl1_ff[C1_TB0F] & ctl1_ff[C1_TB0E],
                   ctl1_ff[C1_S3F] & ctl1_ff[C1_S3E],
                   ctl1_ff[C1_S2F] & ctl1_ff[C1_S2E],
                   ctl0_ff[C0_S0F] & ctl0_ff[C0_S0E],
                   ctl0_ff[C0_PAF] & ctl0_ff[C0_PAE],
                   ctl0_ff[C0_PROTF] & ctl0_ff[C0_PROTE]};                  // [RQ18]

  logic [3:0] nxt_vec;
  always_comb begin
    nxt_vec = 4'h0;
    for (int i = NUM_VEC - 1; i >= 0; i--) begin
      if (pend_w[i]) nxt_vec = 4'(i);                                       // [RQ22]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= '0;
    end else begin
      irq.req <= ctl0_ff[C0_GIE] & (|pend_w) & ~take_ack_w;                 // [RQ14]
      irq.vec <= nxt_vec;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) wake <= 1'b0;
    else     wake <= (|ctl0_ff[C0_S0F:C0_PROTF]) | (|ctl1_ff[C1_TB0F:C1_S2F])
                   | (|ctl2_ff[C2_ADF:C2_TB1F]) | (|grp0_ff[G_M1F:G_M0F])
                   | (|grp2_ff[G_M1F:G_M0F]) | (|grp3_ff[G_M1F:G_M0F]);     // [RQ12] [RQ20]
  end

  // ---------------- read data ----------------
  logic [31:0] nxt_rdata;
  always_comb begin
    unique case ({haddr[7:2], 2'h0})
      ADDR_EDGE_SEL:   nxt_rdata = {24'h0, edge_sel_ff};
      ADDR_PRIM_CTL0:  nxt_rdata = {24'h0, ctl0_ff};
      ADDR_PRIM_CTL1:  nxt_rdata = {24'h0, ctl1_ff};
      ADDR_PRIM_CTL2:  nxt_rdata = {24'h0, ctl2_ff};
      ADDR_GROUP0:     nxt_rdata = {24'h0, grp0_ff};
      ADDR_GROUP2:     nxt_rdata = {24'h0, grp2_ff};
      ADDR_GROUP3:     nxt_rdata = {24'h0, grp3_ff};
      ADDR_LVD_CTL:    nxt_rdata = {26'h0, low_supply_out, lvd_ctl_ff};    // [RQ8]
      ADDR_TOUCH_CTL:  nxt_rdata = {24'h0, tk_ctl_ff[7:5], running_w, tk_ctl_ff[3:0]};
      ADDR_TOUCH_SLOT: nxt_rdata = {24'h0, tk_slot_preset_ff};
      ADDR_TOUCH_CF:   nxt_rdata = {16'h0, tk_cf_result_ff};
      ADDR_TOUCH_GEN:  nxt_rdata = {16'h0, tk_gen_result_ff};
      default:         nxt_rdata = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst)                  hrdata <= 32'h0000_0000;
    else if (take_w && !hwrite) hrdata <= nxt_rdata;
  end

  // ---------------- assertions ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic tk_wr_w;
  assign tk_wr_w = wr_to(ADDR_TOUCH_CTL, wr_pend_ff, wr_addr_ff);

  touch_ovf_a: assert property (slot_ovf_w |=> ctl2_ff[C2_TKF] && tk_ctl_ff[TK_SLOT_OV]
      && slot_cnt_ff == 8'h00 && cf_cnt_ff == 16'h0000 && !running_w) // [RQ1] [RQ2]
    else $error("slot overflow did not flag and clear");
  scan_start_a: assert property ($rose(tk_ctl_ff[TK_START]) && !running_w
      |=> running_w && slot_cnt_ff == tk_slot_preset_ff) // [RQ3]
    else $error("scan did not start on rising start bit");
  slot_hold_a: assert property (tk_ctl_ff[TK_SLOT_OV] && !tk_wr_w
      |=> tk_ctl_ff[TK_SLOT_OV]) // [RQ4]
    else $error("slot overflow flag dropped without software");
  cf_ovf_a: assert property (cf_ovf_w |=> tk_ctl_ff[TK_CF_OV] && cf_cnt_ff == 16'h0000) // [RQ5]
    else $error("frequency overflow not flagged");
  gen_ovf_a: assert property (gen_ovf_w |=> tk_ctl_ff[TK_GEN_OV]) // [RQ6]
    else $error("general overflow not flagged");
  lvd_off_a: assert property (!supply_monitor_enable |-> !low_supply_out) // [RQ9]
    else $error("low supply reported while monitor off");
  lvd_delay_a: assert property ($rose(grp3_ff[G_M0F]) && !$past(wr_pend_ff)
      |-> $past(low_supply_out) && $past(lv_cnt_ff) == 16'(LOW_SUPPLY_IRQ_CYC - 1)) // [RQ11]
    else $error("low supply request not after the fixed delay");
  pin_edge_a: assert property (rise_w[0] && edge_sel_ff[1:0] == EDGE_RISE
      |=> ctl0_ff[C0_PAF]) // [RQ13]
    else $error("pin a rising edge not latched");
  global_en_a: assert property (!$past(ctl0_ff[C0_GIE]) |-> !irq.req) // [RQ14]
    else $error("request issued while globally disabled");
  ack_clear_a: assert property (take_ack_w |=> !ctl0_ff[C0_GIE] ##1 !irq.req) // [RQ19] [RQ22]
    else $error("acceptance did not clear global enable");
  wake_a: assert property (ctl2_ff[C2_TKF] |=> wake) // [RQ20]
    else $error("pending flag did not wake");

  scan_done_c: cover property (running_w ##[1:1000] slot_ovf_w);
  lvd_irq_c:   cover property (lv_set_w);
  ack_c:       cover property (irq.req ##1 irq_ack);
  shared_c:    cover property (grp_rise_w[0] ##1 ctl0_ff[C0_S0F]);

endmodule : irc_top

/* verif/irc_core_model.sv */
module irc_core_model (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire irc_pkg::irc_irq_s irq,
  input  wire logic [3:0]        lat,
  output logic                   irq_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  import irc_pkg::*;
  logic [3:0] cnt_ff;
  // accept a standing request after lat cycles, one-cycle pulse
  always_ff @(posedge clk) begin
    if (rst || irq_ack || !irq.req) begin
      irq_ack <= 1'b0;
      cnt_ff  <= 4'h0;
    end else if (cnt_ff >= lat) begin
      irq_ack <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end
endmodule : irc_core_model

/* verif/irc_top_test.sv */
module irc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import irc_pkg::*;
  logic        clk, rst, hsel, hwrite, hready, hreadyout, hresp, rd_ff;
  logic        ext_pin_a, ext_pin_b, supply_below, touch_ref_osc, irq_ack, wake;
  logic        supply_monitor_enable, touch_osc_run;
  logic [1:0]  htrans, touch_key_osc;
  logic [2:0]  hsize, supply_threshold_sel;
  logic [3:0]  lat;
  logic [7:0]  rv;
  logic [15:0] rq[$];
  logic [3:0]  vq[$];
  logic [31:0] haddr, hwdata, hrdata;
  irc_event_s  events;
  irc_irq_s    irq;
  int          n_errors, cmp_count;
  assign hready = hreadyout;
  irc_top u_dut (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hrdata, .hresp, .ext_pin_a, .ext_pin_b, .supply_below, .touch_key_osc,
    .touch_ref_osc, .supply_monitor_enable, .supply_threshold_sel, .touch_osc_run,
    .events, .irq, .irq_ack, .wake);
  irc_core_model u_core (.clk, .rst, .irq, .lat, .irq_ack);
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic err(input string s);
    n_errors++;
    $display("MISMATCH %0t %s", $time, s);
  endtask : err
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) err("port level");
  endtask : chk
  task automatic hold();
    for (int i = 0; i < 21; i++) begin
      @(posedge clk);
      if (hready === 1'b1) return;
    end
    err("bus timeout");
    complete_run();
  endtask : hold
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    hold();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    hold();
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    rq.push_back({e, m});
    bus(a, 1'b0, 8'h00);
  endtask : rd
  task automatic pin_chk(input logic v, input logic f);
    ext_pin_a <= v;
    ext_pin_b <= v;
    repeat (8) @(posedge clk);
    rd(ADDR_PRIM_CTL0, {2'h0, f, 5'h0}, 8'hff);
    rd(ADDR_PRIM_CTL2, {2'h0, f, 5'h0}, 8'hff);
    wr(ADDR_PRIM_CTL0, 8'h00);
    wr(ADDR_PRIM_CTL2, 8'h00);
  endtask : pin_chk
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rd_ff) begin
      cmp_count++;
      if (rq.size() == 0 || (hrdata[7:0] & rq[0][7:0]) !== rq[0][15:8]) err("read data");
      if (rq.size() != 0) rq.delete(0);
    end
    if (irq_ack === 1'b1 && irq.req === 1'b1) begin
      cmp_count++;
      if (vq.size() == 0 || irq.vec !== vq[0]) err("vector");
      if (vq.size() != 0) vq.delete(0);
    end
    rd_ff <= hsel && htrans[1] && !hwrite && hready;
  end
  initial begin
    {rst, hsel, hwrite, htrans, haddr, hwdata} = {1'b1, 68'h0};
    {ext_pin_a, ext_pin_b, supply_below, touch_ref_osc, rd_ff} = 5'h0;
    {hsize, touch_key_osc, lat, events} = {3'h2, 6'h0, 9'h0};
    n_errors = 0;
    cmp_count = 0;
    rv = 8'($urandom(32'hd3d4));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int a = 0; a <= 8'h30; a += 4) rd(8'(a), 8'h00, 8'hff);
    chk({7'h0, hresp}, 8'h00);
    $display("test reset done");
    rv = 8'($urandom) & 8'h7e;
    wr(ADDR_PRIM_CTL0, rv);
    rd(ADDR_PRIM_CTL0, rv, 8'hff);
    wr(ADDR_PRIM_CTL0, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_EDGE_SEL, {4'h0, 2'(m), 2'(m)});
      pin_chk(1'b1, m[0]);
      pin_chk(1'b0, m[1]);
    end
    wr(ADDR_EDGE_SEL, 8'h00);
    events.protection <= 1'b1;
    events.ctm_a      <= 1'b1;
    @(posedge clk);
    events <= '0;
    rd(ADDR_PRIM_CTL0, 8'h10, 8'hff);
    rd(ADDR_GROUP0, 8'h20, 8'hff);
    $display("test edges done");
    lat <= 4'($urandom_range(0, 9));
    vq.push_back(VEC_PROT);
    wr(ADDR_PRIM_CTL0, 8'h37);
    repeat (20) @(posedge clk);
    rd(ADDR_PRIM_CTL0, 8'h26, 8'hff);
    vq.push_back(VEC_PIN_A);
    wr(ADDR_PRIM_CTL0, 8'h27);
    repeat (20) @(posedge clk);
    rd(ADDR_PRIM_CTL0, 8'h06, 8'hff);
    $display("test service done");
    rv = 8'($urandom_range(0, 7));
    wr(ADDR_GROUP3, 8'h01);
    wr(ADDR_PRIM_CTL1, 8'h00);
    wr(ADDR_LVD_CTL, 8'h10 | rv);
    @(posedge clk);
    chk({4'h0, supply_monitor_enable, supply_threshold_sel}, 8'h08 | rv);
    supply_below <= 1'b1;
    repeat (10) @(posedge clk); // settle before polling
    rd(ADDR_LVD_CTL, 8'h30 | rv, 8'hff);
    repeat (LOW_SUPPLY_IRQ_CYC - 40) @(posedge clk);
    rd(ADDR_GROUP3, 8'h01, 8'hff);
    repeat (80) @(posedge clk);
    rd(ADDR_GROUP3, 8'h11, 8'hff);
    rd(ADDR_PRIM_CTL1, 8'h40, 8'hff);
    chk({7'h0, wake}, 8'h01);
    wr(ADDR_LVD_CTL, 8'h00);
    rd(ADDR_LVD_CTL, 8'h00, 8'hff);
    $display("test supply done");
    wr(ADDR_TOUCH_SLOT, 8'hff);
    wr(ADDR_TOUCH_CTL, 8'h0b);
    repeat (2) @(posedge clk);
    chk({7'h0, touch_osc_run}, 8'h01);
    // toggle the disabled second key only: it must not be counted
    for (int i = 0; i < 40; i++) begin
      touch_key_osc <= {~touch_key_osc[1], 1'b0};
      @(posedge clk);
    end
    repeat (160) @(posedge clk);
    chk({7'h0, touch_osc_run}, 8'h00);
    rd(ADDR_TOUCH_CTL, 8'h20, 8'h30);
    rd(ADDR_PRIM_CTL2, 8'h40, 8'h40);
    rd(ADDR_TOUCH_CF, 8'h00, 8'hff);
    $display("test touch done");
    repeat (2) @(posedge clk);
    if (rq.size() != 0) err("missing read");
    if (vq.size() != 0) err("missing accept");
    complete_run();
  end
endmodule : irc_top_test
